/* verilog/sdl_dev.sv */
// Purpose: converter end: shift register, code register, load control
// Assumes: link sclk is the shift clock; ref_clk_i sees frame, strobe, the full flag and the code
// Notes: strobe and frame edges are sampled on ref_clk_i after two flops
// How it works
// R1: code register is zero after power-up
// R2: shift register is never cleared by reset
// R3: long frames keep only the last sixteen bits
// R4: short frames keep older bits, shifted up
// R5: host sends a full word first
// R6: host left-aligns short data, zero filled
// R7: data sampled on each serial clock rise
// R8: clock, data, frame select, optional strobe
// R9: only one device select at a time
// R10: host toggles serial clock only in frames
// R11: msb first, only while frame select low
// R12: frame end loads code when strobe low
// R13: strobe fall loads held word into code
// R14: clock and data ignored while deselected
`timescale 1ns/1ps
module sdl_dev (
  // system
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link
  sdl_link_if.dev link,
  // converter code
  output sdl_pkg::sdl_word_t code_o,
  output logic code_load_o
);
  import sdl_pkg::*;
  // index of each slow signal in the synchroniser array
  localparam int PIN_FRAME = 0;
  localparam int PIN_STB = 1;
  localparam int PIN_FULL = 2;
  localparam int PIN_N = 3;
  // idle levels after reset: frame high, strobe low (host default), no full word yet
  localparam logic [PIN_N-1:0] SYNC_RST = 3'h1;
  sdl_word_t shift_reg;
  sdl_word_t shift_next;
  sdl_word_t shift_in;
  logic [4:0] bits_reg;
  logic [4:0] bits_next;
  logic full_reg;
  logic full_next;
  sdl_word_t code_reg;
  sdl_word_t code_next;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync1_reg;
  logic [PIN_N-1:0] sync1_next;
  logic [PIN_N-1:0] sync2_reg;
  logic [PIN_N-1:0] sync2_next;
  logic [PIN_N-1:0] old_reg;
  logic [PIN_N-1:0] old_next;
  logic load_reg;
  logic load_next;
  logic frame_rise;
  logic stb_fall;

  // msb first; extra bits push oldest out, short frames keep old bits [R3] [R4] [R7]
  for (genvar b = 0; b < SDL_WORD_W; b++)
  begin : g_shift
    if (b == 0)
    begin : g_first
      assign shift_in[b] = link.sdata;
    end
    else
    begin : g_rest
      assign shift_in[b] = shift_reg[b-1];
    end
  end

  // shift register has no reset on purpose: power-up contents undefined [R2]
  always_comb
  begin
    shift_next = shift_reg;
    if (!link.frame_n) // bits only while selected [R11] [R14] [R8]
    begin
      shift_next = shift_in;
    end
  end

  always_ff @(posedge link.sclk)
  begin
    shift_reg <= shift_next;
  end

  // counts bits since reset until a whole word has passed; only then is the
  // shift register fully defined and safe for a strobe load
  always_comb
  begin
    bits_next = bits_reg;
    full_next = full_reg;
    if (!link.frame_n && !full_reg)
    begin
      bits_next = bits_reg + 5'h01;
      full_next = (bits_reg == 5'(SDL_WORD_W - 1));
    end
  end

  // reset released while the burst clock is idle, so no recovery hazard
  always_ff @(posedge link.sclk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bits_reg <= SDL_BITS_RST;
      full_reg <= 1'b0;
    end
    else
    begin
      bits_reg <= bits_next;
      full_reg <= full_next;
    end
  end

  // full_reg comes from a flop, so it is glitch free before the crossing
  assign pin_raw = {full_reg, link.load_strobe_n, link.frame_n};

  // two flops per slow signal, then one more for edge detection
  for (genvar p = 0; p < PIN_N; p++)
  begin : g_sync
    assign sync1_next[p] = pin_raw[p];
    assign sync2_next[p] = sync1_reg[p];
    assign old_next[p] = sync2_reg[p];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      old_reg <= SYNC_RST;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      old_reg <= old_next;
    end
  end

  assign frame_rise = sync2_reg[PIN_FRAME] & ~old_reg[PIN_FRAME];
  assign stb_fall = ~sync2_reg[PIN_STB] & old_reg[PIN_STB];

  // shift_reg is stable here: frame high stops sclk shifting, synchroniser delays use
  always_comb
  begin
    code_next = code_reg;
    load_next = 1'b0;
    if (frame_rise && !sync2_reg[PIN_STB]) // update at frame end if strobe low [R12]
    begin
      code_next = shift_reg;
      load_next = 1'b1;
    end
    else if (stb_fall && sync2_reg[PIN_FRAME] && sync2_reg[PIN_FULL]) // held word [R13]
    begin
      code_next = shift_reg;
      load_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      code_reg <= SDL_CODE_RST; // zero until first load [R1]
      load_reg <= 1'b0;
    end
    else
    begin
      code_reg <= code_next;
      load_reg <= load_next;
    end
  end

  assign code_o = code_reg;
  assign code_load_o = load_reg;
endmodule

/* verilog/sdl_pkg.sv */
// Purpose: shared constants and types for the serial converter load path
// Assumes: 16-bit words, frames of 1 to 31 bits, most significant bit first
// Notes: the host divides ref_clk_i to make the link clock
package sdl_pkg;
  localparam int SDL_WORD_W = 16;
  localparam logic [15:0] SDL_CODE_RST = 16'h0000;
  // host serial clock half period in ref_clk_i cycles
  localparam logic [3:0] SDL_HALF_DIV = 4'h2;
  // host strobe low width in ref_clk_i cycles
  localparam logic [3:0] SDL_STB_LEN = 4'h4;
  localparam logic [4:0] SDL_BITS_RST = 5'h00;
  typedef logic [SDL_WORD_W-1:0] sdl_word_t;
  typedef enum logic [4:0] {
    SDL_IDLE = 5'b00001,
    SDL_LOW = 5'b00010,
    SDL_HIGH = 5'b00100,
    SDL_END = 5'b01000,
    SDL_STB = 5'b10000
  } sdl_state_t;
endpackage

/* verilog/sdl_link_if.sv */
// Purpose: link wires between host and converter load path
// Assumes: only one device select driven per device
// Notes: all wires are one-way, host to device
`timescale 1ns/1ps
interface sdl_link_if;
  logic sclk;
  logic sdata;
  logic frame_n;
  logic load_strobe_n;
  modport host (output sclk, output sdata, output frame_n, output load_strobe_n);
  modport dev (input sclk, input sdata, input frame_n, input load_strobe_n);
endinterface

/* verilog/sdl_host.sv */
// Purpose: host end: sends nbits_i bits per request, zero meaning 16, optional strobe
// Assumes: a decoder outside gives one device select at a time
// Notes: sclk toggles only inside frames; shorter data is left-aligned by user
`timescale 1ns/1ps
module sdl_host (
  // system
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // request
  input wire logic req_i,
  input sdl_pkg::sdl_word_t word_i,
  input wire logic [4:0] nbits_i,
  input wire logic strobe_mode_i,
  output logic ready_o,
  output logic done_o,
  // link
  sdl_link_if.host link
);
  import sdl_pkg::*;
  sdl_state_t state_reg;
  sdl_state_t state_next;
  sdl_word_t data_reg;
  sdl_word_t data_next;
  logic [4:0] bits_reg;
  logic [4:0] bits_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic mode_reg;
  logic mode_next;
  logic done_reg;
  logic done_next;

  always_comb
  begin
    state_next = state_reg;
    data_next = data_reg;
    bits_next = bits_reg;
    cnt_next = cnt_reg;
    mode_next = mode_reg;
    done_next = 1'b0;
    unique case (state_reg)
      SDL_IDLE:
      begin
        if (req_i)
        begin
          data_next = word_i; // short data comes left-aligned, low bits zero [R6]
          // zero bits is taken as a full word so power-up load is complete [R5]
          bits_next = (nbits_i == SDL_BITS_RST) ? 5'h10 : nbits_i;
          mode_next = strobe_mode_i;
          cnt_next = SDL_HALF_DIV;
          state_next = SDL_LOW;
        end
      end
      SDL_LOW:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          cnt_next = SDL_HALF_DIV;
          state_next = SDL_HIGH; // rising edge: data already stable [R7]
        end
      end
      SDL_HIGH:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          cnt_next = SDL_HALF_DIV;
          data_next = {data_reg[SDL_WORD_W-2:0], 1'b0}; // msb first [R11]
          bits_next = bits_reg - 5'h01;
          state_next = (bits_reg == 5'h01) ? SDL_END : SDL_LOW;
        end
      end
      SDL_END:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          cnt_next = SDL_STB_LEN;
          state_next = mode_reg ? SDL_STB : SDL_IDLE;
          done_next = !mode_reg;
        end
      end
      SDL_STB:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          state_next = SDL_IDLE;
          done_next = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= SDL_IDLE;
      data_reg <= SDL_CODE_RST;
      bits_reg <= SDL_BITS_RST;
      cnt_reg <= 4'h0;
      mode_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      data_reg <= data_next;
      bits_reg <= bits_next;
      cnt_reg <= cnt_next;
      mode_reg <= mode_next;
      done_reg <= done_next;
    end
  end

  // burst clock: high only in SDL_HIGH, idle low otherwise [R10] [R8]
  assign link.sclk = (state_reg == SDL_HIGH);
  assign link.sdata = data_reg[SDL_WORD_W-1];
  // frame held low through the last bit; strobe low after frame in strobe mode [R9] [R12]
  assign link.frame_n = !(state_reg == SDL_LOW || state_reg == SDL_HIGH);
  // strobe held high through the frame in strobe mode to defer load; low in direct mode [R13]
  assign link.load_strobe_n = mode_reg ? (state_reg != SDL_STB) : 1'b0;
  assign ready_o = (state_reg == SDL_IDLE);
  assign done_o = done_reg;
endmodule

/* bench/sdl_link_monitor.sv */
// Purpose: link and code checks for the load path
// Assumes: host half period of two ref_clk_i cycles
// Notes: all checks sleep while in reset
`timescale 1ns/1ps
module sdl_link_monitor
  import sdl_pkg::*;
(
  // system
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // link and code
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frame_n,
  input wire logic load_strobe_n,
  input sdl_word_t code_o,
  input wire logic code_load_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_gate; frame_n |-> !sclk; endproperty
  a_gate: assert property (p_gate) else $error("sclk outside frame");
  property p_setup; $rose(sclk) |-> $stable(sdata); endproperty
  a_setup: assert property (p_setup) else $error("sdata moved at rise");
  property p_hi; $rose(sclk) |=> sclk ##1 !sclk; endproperty
  a_hi: assert property (p_hi) else $error("sclk high width");
  property p_start; $fell(frame_n) |-> !sclk ##1 !sclk ##1 sclk; endproperty
  a_start: assert property (p_start) else $error("first rise late");
  property p_end; $rose(frame_n) && !load_strobe_n |-> ##[1:6] code_load_o; endproperty
  a_end: assert property (p_end) else $error("no load at frame end");
  property p_keep; $rose(frame_n) && load_strobe_n |-> !code_load_o[*3]; endproperty
  a_keep: assert property (p_keep) else $error("load with strobe high");
  property p_stb; $fell(load_strobe_n) && frame_n |-> ##[1:6] code_load_o; endproperty
  a_stb: assert property (p_stb) else $error("no load on strobe");
  property p_chg; $changed(code_o) |-> code_load_o; endproperty
  a_chg: assert property (p_chg) else $error("code moved unloaded");
  c_end: cover property ($rose(frame_n) && !load_strobe_n);
  c_stb: cover property ($fell(load_strobe_n) && frame_n);
  c_load: cover property (code_load_o);
endmodule

/* bench/tb.sv */
// Purpose: host and converter ends joined over the link
// Assumes: one converter on the link
// Notes: rows hold word, bit count, mode and expected code
`timescale 1ns/1ps
module tb;
  import sdl_pkg::*;
  typedef struct {sdl_word_t w; logic [4:0] n; logic m; sdl_word_t e;} sdl_row_t;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  sdl_word_t word_i = 16'h0000;
  logic [4:0] nbits_i = 5'h00;
  logic strobe_mode_i = 1'b0;
  logic ready_o;
  logic done_o;
  logic code_load_o;
  sdl_word_t code_o;
  int err_total = 0;
  int cmp_count = 0;
  // third row sends 8 left-aligned bits so the old low byte moves up
  sdl_row_t rows [3] = '{'{16'hA5C3, 5'h00, 1'b0, 16'hA5C3},
    '{16'h1234, 5'h10, 1'b1, 16'h1234}, '{16'hFF00, 5'h08, 1'b0, 16'h34FF}};
  sdl_link_if link ();
  sdl_host sdl_host_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .word_i(word_i), .nbits_i(nbits_i), .strobe_mode_i(strobe_mode_i),
    .ready_o(ready_o), .done_o(done_o), .link(link.host));
  sdl_dev sdl_dev_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link.dev),
    .code_o(code_o), .code_load_o(code_load_o));
  sdl_link_monitor sdl_link_monitor_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .sclk(link.sclk), .sdata(link.sdata), .frame_n(link.frame_n),
    .load_strobe_n(link.load_strobe_n), .code_o(code_o), .code_load_o(code_load_o));
  always #2 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string s, input sdl_word_t e, input sdl_word_t g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic send(input sdl_word_t w, input logic [4:0] n, input logic m);
    int k;
    @(posedge ref_clk_i);
    req_i <= 1'b1;
    word_i <= w;
    nbits_i <= n;
    strobe_mode_i <= m;
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 200)
    begin
      @(posedge ref_clk_i) #1;
      k++;
    end
    // load lands a few cycles after the frame or strobe edge
    repeat (8) @(posedge ref_clk_i);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1 chk("code", SDL_CODE_RST, code_o);
    foreach (rows[i])
    begin
      send(rows[i].w, rows[i].n, rows[i].m);
      chk("code", rows[i].e, code_o);
    end
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1 chk("code", SDL_CODE_RST, code_o);
    send(16'h00F0, 5'h10, 1'b1);
    chk("code", 16'h00F0, code_o);
    end_sim();
  end
  initial
  begin
    repeat (3000) @(posedge ref_clk_i);
    err_total++;
    end_sim();
  end
endmodule
